// *** hw/address_protection_checker.sv ***
// address protection checker: segment decode, range and page checks, trap raise
`timescale 1ns/1ps
module address_protection_checker
    import prot_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // cpu access request and processor state
    input wire access_t acc,
    input wire logic virtual_mode,
    input wire logic [1:0] protection_set_select,
    input wire page_perm_t page_entry,
    // checked access toward memory
    output logic grant,
    output logic [31:0] phys_addr_q,
    output logic grant_valid_q,
    // trap and debug
    output fault_t trap_handler,
    output logic virtual_address_protection_trap,
    output logic debug_illegal_q,
    output logic irq
);
    // range bounds and mode registers
    logic [31:0] dlo_q [NUM_SETS][NUM_DRANGE];
    logic [31:0] dhi_q [NUM_SETS][NUM_DRANGE];
    logic [31:0] clo_q [NUM_SETS][NUM_CRANGE];
    logic [31:0] chi_q [NUM_SETS][NUM_CRANGE];
    logic [31:0] mode_q [NUM_SETS];
    logic enable_q;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic [31:0] faddr_q;
    logic [3:0] finfo_q;
    fault_t trap_q;
    logic priv_q;

    // half-open range test
    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        return (a >= lo) && (a < hi);
    endfunction

    // register offsets shared by the write decode and the read mux
    function automatic logic [11:0] mode_off(input int s);
        return OFF_MBASE + 12'(s * 4);
    endfunction

    // data range bound offset; hi picks the upper bound of the pair
    function automatic logic [11:0] drange_off(input int s, input int i, input logic hi);
        return OFF_DBASE + 12'((s * NUM_DRANGE + i) * 8) + (hi ? 12'h004 : 12'h000);
    endfunction

    // code range bound offset; hi picks the upper bound of the pair
    function automatic logic [11:0] crange_off(input int s, input int i, input logic hi);
        return OFF_CBASE + 12'((s * NUM_CRANGE + i) * 8) + (hi ? 12'h004 : 12'h000);
    endfunction

    logic [3:0] seg;
    logic upper_half;
    logic direct;
    logic range_ok;
    logic page_ok;
    logic priv_hit;
    logic illegal;
    logic [1:0] set;

    assign seg = acc.addr[SEG_MSB:SEG_LSB];
    assign upper_half = seg[3];
    assign direct = upper_half || !virtual_mode;
    assign set = protection_set_select;

    // range check over the selected set's data or code part
    always_comb begin
        range_ok = 1'b0;
        if (acc.kind == ACC_FETCH) begin
            for (int i = 0; i < NUM_CRANGE; i++) begin
                if (in_range(acc.addr, clo_q[set][i], chi_q[set][i]) && mode_q[set][MODE_EX_POS + i]) begin
                    range_ok = 1'b1;
                end
            end
        end else begin
            for (int i = 0; i < NUM_DRANGE; i++) begin
                if (in_range(acc.addr, dlo_q[set][i], dhi_q[set][i])) begin
                    if (acc.kind == ACC_WRITE && mode_q[set][MODE_WR_POS + i]) begin
                        range_ok = 1'b1;
                    end
                    if (acc.kind == ACC_READ && mode_q[set][MODE_RD_POS + i]) begin
                        range_ok = 1'b1;
                    end
                end
            end
        end
    end

    // page entry permission check
    always_comb begin
        unique case (acc.kind)
            ACC_FETCH: page_ok = page_entry.execute;
            ACC_WRITE: page_ok = page_entry.write;
            ACC_READ: page_ok = page_entry.read;
            default: page_ok = 1'b0;
        endcase
    end

    // privilege restriction on least-privileged accesses
    always_comb begin
        priv_hit = 1'b0;
        if (acc.least_priv) begin
            if (virtual_mode) begin
                priv_hit = upper_half;
            end else begin
                priv_hit = (seg == SEG_RESTRICT_A) || (seg == SEG_RESTRICT_B);
            end
        end
    end

    // refusal terms; range and page checks are bypassed while disabled, privilege always applies
    logic check_fail;
    logic priv_fault;
    logic check_fault;
    assign check_fail = direct ? !range_ok : !page_ok;
    assign priv_fault = acc.valid && priv_hit;
    assign check_fault = acc.valid && !priv_hit && enable_q && check_fail;

    // final verdict and level outputs
    assign illegal = priv_fault || check_fault;
    assign grant = acc.valid && !illegal;
    assign trap_handler = trap_q;
    assign virtual_address_protection_trap = priv_q;
    assign irq = |(status_q & mask_q);

    // granted accesses reach memory one cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            grant_valid_q <= 1'b0;
        end else begin
            grant_valid_q <= grant;
        end
    end

    // pass-through physical address of the last granted access
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phys_addr_q <= RST_ZERO;
        end else if (grant) begin
            phys_addr_q <= acc.addr;
        end
    end

    // trap request pulse carrying the refused access, one cycle after it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trap_q <= '0;
        end else begin
            trap_q.prot_trap <= check_fault;
            trap_q.priv_trap <= priv_fault;
            trap_q.addr <= acc.addr;
            trap_q.kind <= acc.kind;
        end
    end

    // privilege trap and debug indication pulses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            priv_q <= 1'b0;
            debug_illegal_q <= 1'b0;
        end else begin
            priv_q <= priv_fault;
            debug_illegal_q <= illegal;
        end
    end

    // ahb-lite address phase capture
    logic dp_active_q;
    logic dp_write_q;
    logic [11:0] dp_addr_q;
    logic take;
    assign take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_active_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q <= 12'h000;
        end else if (hready) begin
            dp_active_q <= take;
            dp_write_q <= hwrite;
            dp_addr_q <= haddr[11:0];
        end
    end

    logic wr_en;
    logic rd_status;
    assign wr_en = dp_active_q && dp_write_q;
    assign rd_status = take && !hwrite && (haddr[11:0] == OFF_STATUS);

    // control and mask register writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_q <= 1'b0;
            mask_q <= 2'b00;
        end else if (wr_en) begin
            if (dp_addr_q == OFF_CTRL) begin
                enable_q <= hwdata[0];
            end
            if (dp_addr_q == OFF_MASK) begin
                mask_q <= hwdata[1:0];
            end
        end
    end

    // mode register writes, one per set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int s = 0; s < NUM_SETS; s++) begin
                mode_q[s] <= RST_ZERO;
            end
        end else if (wr_en) begin
            for (int s = 0; s < NUM_SETS; s++) begin
                if (dp_addr_q == mode_off(s)) begin
                    mode_q[s] <= hwdata;
                end
            end
        end
    end

    // data range bound writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int s = 0; s < NUM_SETS; s++) begin
                for (int i = 0; i < NUM_DRANGE; i++) begin
                    dlo_q[s][i] <= RST_ZERO;
                    dhi_q[s][i] <= RST_ZERO;
                end
            end
        end else if (wr_en) begin
            for (int s = 0; s < NUM_SETS; s++) begin
                for (int i = 0; i < NUM_DRANGE; i++) begin
                    if (dp_addr_q == drange_off(s, i, 1'b0)) begin
                        dlo_q[s][i] <= hwdata;
                    end
                    if (dp_addr_q == drange_off(s, i, 1'b1)) begin
                        dhi_q[s][i] <= hwdata;
                    end
                end
            end
        end
    end

    // code range bound writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int s = 0; s < NUM_SETS; s++) begin
                for (int i = 0; i < NUM_CRANGE; i++) begin
                    clo_q[s][i] <= RST_ZERO;
                    chi_q[s][i] <= RST_ZERO;
                end
            end
        end else if (wr_en) begin
            for (int s = 0; s < NUM_SETS; s++) begin
                for (int i = 0; i < NUM_CRANGE; i++) begin
                    if (dp_addr_q == crange_off(s, i, 1'b0)) begin
                        clo_q[s][i] <= hwdata;
                    end
                    if (dp_addr_q == crange_off(s, i, 1'b1)) begin
                        chi_q[s][i] <= hwdata;
                    end
                end
            end
        end
    end

    // sticky status; a new event wins over the read clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= 2'b00;
        end else begin
            status_q <= (rd_status ? 2'b00 : status_q) | {priv_fault, check_fault};
        end
    end

    // address and kind of the latest refused access
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            faddr_q <= RST_ZERO;
            finfo_q <= 4'h0;
        end else if (illegal) begin
            faddr_q <= acc.addr;
            finfo_q <= {acc.least_priv, direct, acc.kind};
        end
    end

    // read data mux, registered into the data phase
    logic [31:0] rdata_d;
    always_comb begin
        rdata_d = RST_ZERO;
        unique case (haddr[11:0])
            OFF_CTRL: rdata_d = {31'h0, enable_q};
            OFF_STATUS: rdata_d = {30'h0, status_q};
            OFF_MASK: rdata_d = {30'h0, mask_q};
            OFF_FADDR: rdata_d = faddr_q;
            OFF_FINFO: rdata_d = {28'h0, finfo_q};
            default: begin
                for (int s = 0; s < NUM_SETS; s++) begin
                    if (haddr[11:0] == mode_off(s)) begin
                        rdata_d = mode_q[s];
                    end
                    for (int i = 0; i < NUM_DRANGE; i++) begin
                        if (haddr[11:0] == drange_off(s, i, 1'b0)) begin
                            rdata_d = dlo_q[s][i];
                        end
                        if (haddr[11:0] == drange_off(s, i, 1'b1)) begin
                            rdata_d = dhi_q[s][i];
                        end
                    end
                    for (int i = 0; i < NUM_CRANGE; i++) begin
                        if (haddr[11:0] == crange_off(s, i, 1'b0)) begin
                            rdata_d = clo_q[s][i];
                        end
                        if (haddr[11:0] == crange_off(s, i, 1'b1)) begin
                            rdata_d = chi_q[s][i];
                        end
                    end
                end
            end
        endcase
    end

    // read data taken in the address phase stands until the next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= RST_ZERO;
        end else if (take && !hwrite) begin
            hrdata <= rdata_d;
        end
    end
endmodule

// *** hw/prot_pkg.sv ***
// constants, types and rule summary for the address protection checker
// What this block does
// - top four address bits select one of sixteen 256 MB segments.
// - upper-half addresses pass unchanged and use direct translation.
// - lower half is direct in physical mode, page-translated in virtual mode.
// - direct accesses use range sets chosen by protection_set_select, four sets.
// - each set's data part holds up to four ranges for loads and stores.
// - each set's code part holds up to two ranges for fetches.
// - each part holds bound register pairs; one mode register per set serves both parts.
// - page-translated fetch needs page_execute_enable set.
// - page-translated write needs the page write enable set.
// - page-translated read needs page_read_enable set.
// - virtual mode refuses least-privileged access to the upper half.
// - physical mode refuses least-privileged access only to segments 14, 15.
// - such restricted least-privileged access raises virtual_address_protection_trap.
// - illegal accesses are detected, not performed; a trap_handler request is raised.
// - indication signals to the debug unit trace illegal accesses.
package prot_pkg;
    localparam int unsigned SEG_MSB = 31;
    localparam int unsigned SEG_LSB = 28;
    localparam logic [3:0] SEG_RESTRICT_A = 4'hE;
    localparam logic [3:0] SEG_RESTRICT_B = 4'hF;
    localparam int unsigned NUM_SETS = 4;
    localparam int unsigned NUM_DRANGE = 4;
    localparam int unsigned NUM_CRANGE = 2;
    // register map, word aligned
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_MASK = 12'h008;
    localparam logic [11:0] OFF_FADDR = 12'h00C;
    localparam logic [11:0] OFF_FINFO = 12'h010;
    localparam logic [11:0] OFF_DBASE = 12'h100;
    localparam logic [11:0] OFF_CBASE = 12'h200;
    localparam logic [11:0] OFF_MBASE = 12'h300;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    // mode register bits: data part read/write enable, code part execute enable per range
    localparam int unsigned MODE_RD_POS = 0;
    localparam int unsigned MODE_WR_POS = 8;
    localparam int unsigned MODE_EX_POS = 16;
    // status bits
    localparam int unsigned ST_PROT = 0;
    localparam int unsigned ST_PRIV = 1;

    typedef enum logic [1:0] {
        ACC_READ = 2'b00,
        ACC_WRITE = 2'b01,
        ACC_FETCH = 2'b10
    } acc_kind_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        acc_kind_t kind;
        logic least_priv;
    } access_t;

    typedef struct packed {
        logic execute;
        logic write;
        logic read;
    } page_perm_t;

    typedef struct packed {
        logic prot_trap;
        logic priv_trap;
        logic [31:0] addr;
        acc_kind_t kind;
    } fault_t;
endpackage

// *** sim/cpu_access_model.sv ***
// cpu load/store and fetch unit model presenting one access at a time
`timescale 1ns/1ps
module cpu_access_model
    import prot_pkg::*;
(
    // clock
    input wire logic hclk,
    // access toward the checker
    output access_t acc
);
    initial acc = '{1'b0, 32'h0, ACC_READ, 1'b0};
    // present an access, called just after a rising edge
    task automatic present(input logic [31:0] a, input acc_kind_t k, input logic lp);
        acc <= '{1'b1, a, k, lp};
    endtask
    // withdraw it; the idle bus shows no stale address
    task automatic withdraw();
        acc <= '{1'b0, ~acc.addr, acc.kind, ~acc.least_priv};
    endtask
endmodule

// *** sim/prot_asserts.sv ***
// concurrent checks on the access, trap and debug ports of the protection checker
`timescale 1ns/1ps
module prot_asserts
    import prot_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // access side
    input wire access_t acc,
    input wire logic virtual_mode,
    input wire logic grant,
    input wire logic [31:0] phys_addr_q,
    input wire logic grant_valid_q,
    // trap and debug side
    input wire fault_t trap_handler,
    input wire logic virtual_address_protection_trap,
    input wire logic debug_illegal_q
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // a refused access, then the trap pulse one cycle later
    sequence refused_s;
        acc.valid && !grant;
    endsequence
    sequence trap_s;
        ##1 (trap_handler.prot_trap || trap_handler.priv_trap);
    endsequence
    sequence lp_s;
        acc.valid && acc.least_priv;
    endsequence
    // privilege refusals by mode and segment
    priv_virt_a: assert property (lp_s ##0 (virtual_mode && acc.addr[31]) |-> !grant ##1
        (virtual_address_protection_trap && !trap_handler.prot_trap)) else $error("upper half not refused");
    priv_phys_a: assert property (lp_s ##0 (!virtual_mode && acc.addr[31:29] == 3'b111) |->
        !grant ##1 virtual_address_protection_trap) else $error("segment 14 or 15 not refused");
    phys_open_a: assert property (lp_s ##0 (!virtual_mode && acc.addr[31:29] != 3'b111) |=>
        !virtual_address_protection_trap) else $error("open segment raised privilege trap");
    priv_cause_a: assert property (virtual_address_protection_trap |->
        $past(acc.valid && acc.least_priv) && trap_handler.priv_trap) else $error("privilege trap without cause");
    // every refusal traps with the refused address and kind
    refuse_trap_a: assert property (refused_s |-> trap_s) else $error("refusal without trap");
    trap_addr_a: assert property (refused_s |=> trap_handler.addr == $past(acc.addr) &&
        trap_handler.kind == $past(acc.kind)) else $error("trap carries wrong access");
    debug_flag_a: assert property (1'b1 |=> debug_illegal_q == $past(acc.valid && !grant))
        else $error("debug flag does not follow refusals");
    // granted addresses pass unchanged
    grant_pass_a: assert property (grant |=> grant_valid_q && phys_addr_q == $past(acc.addr))
        else $error("granted address altered");
    no_grant_a: assert property (!grant |=> !grant_valid_q) else $error("refused access performed");
endmodule

// *** sim/test_address_protection_checker.sv ***
// self-checking bench for the address protection checker
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", n, e, s); end end
module test_address_protection_checker;
    import prot_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, phys_addr_q, rd;
    logic hreadyout, hresp, grant, grant_valid_q, vaddr_trap, debug_illegal_q, irq;
    logic virtual_mode = 1'b0;
    logic [1:0] protection_set_select = 2'h0;
    page_perm_t page_entry = 3'h0;
    access_t acc;
    fault_t trap_handler;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    // cpu side model and the design
    cpu_access_model cpu (.hclk(hclk), .acc(acc));
    address_protection_checker DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .acc(acc), .virtual_mode(virtual_mode),
        .protection_set_select(protection_set_select), .page_entry(page_entry), .grant(grant),
        .phys_addr_q(phys_addr_q), .grant_valid_q(grant_valid_q), .trap_handler(trap_handler),
        .virtual_address_protection_trap(vaddr_trap), .debug_illegal_q(debug_illegal_q), .irq(irq));
    // clock and hang guard
    initial forever #25 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // one single ahb transfer; read data lands in rd
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
        #1;
    endtask
    // one cpu access: grant this cycle, trap pulses {prot, vap} the next
    task automatic chk_acc(input logic vm, input logic [31:0] a, input acc_kind_t k, input logic lp,
        input logic g, input logic [1:0] tr);
        @(posedge hclk);
        virtual_mode <= vm;
        cpu.present(a, k, lp);
        #1 `CHK("grant", g, grant)
        @(posedge hclk);
        cpu.withdraw();
        #1 `CHK("trap", tr, {trap_handler.prot_trap, vaddr_trap})
        `CHK("debug", !g, debug_illegal_q)
        if (g) `CHK("phys", a, phys_addr_q)
    endtask
    // reset values, unmapped place ignores writes
    task automatic t_regs();
        logic [11:0] offs [6] = '{OFF_CTRL, OFF_STATUS, OFF_MASK, OFF_FADDR, OFF_FINFO, 12'h0F0};
        ahb(1'b1, 12'h0F0, 32'hFFFF_FFFF);
        foreach (offs[i]) begin
            ahb(1'b0, offs[i], 32'h0);
            `CHK("reset value", RST_ZERO, rd)
        end
    endtask
    // privilege refusals with range checks still off
    task automatic t_priv();
        chk_acc(1'b1, 32'hF000_0000, ACC_READ, 1'b1, 1'b0, 2'b01);
        chk_acc(1'b1, 32'h8000_0000, ACC_FETCH, 1'b1, 1'b0, 2'b01);
        chk_acc(1'b0, 32'hE000_0000, ACC_WRITE, 1'b1, 1'b0, 2'b01);
        chk_acc(1'b0, 32'hD000_0000, ACC_READ, 1'b1, 1'b1, 2'b00);
        chk_acc(1'b0, 32'hF000_0010, ACC_READ, 1'b0, 1'b1, 2'b00);
        chk_acc(1'b1, 32'h1000_0000, ACC_WRITE, 1'b1, 1'b1, 2'b00);
    endtask
    // set 1: data range 0 read-only, code range 0 executable
    task automatic t_ranges();
        ahb(1'b1, 12'h120, 32'h1000_0000);
        ahb(1'b1, 12'h124, 32'h1000_0100);
        ahb(1'b1, 12'h210, 32'h2000_0000);
        ahb(1'b1, 12'h214, 32'h2000_1000);
        ahb(1'b1, 12'h304, 32'h0001_0001);
        ahb(1'b1, OFF_CTRL, 32'h1);
        ahb(1'b0, 12'h124, 32'h0);
        `CHK("upper bound", 32'h1000_0100, rd)
        @(posedge hclk);
        protection_set_select <= 2'h1;
        chk_acc(1'b0, 32'h1000_0000, ACC_READ, 1'b0, 1'b1, 2'b00);
        chk_acc(1'b0, 32'h1000_00FC, ACC_READ, 1'b0, 1'b1, 2'b00);
        chk_acc(1'b0, 32'h1000_0100, ACC_READ, 1'b0, 1'b0, 2'b10);
        chk_acc(1'b0, 32'h0FFF_FFFC, ACC_READ, 1'b0, 1'b0, 2'b10);
        chk_acc(1'b0, 32'h1000_0000, ACC_WRITE, 1'b0, 1'b0, 2'b10);
        chk_acc(1'b0, 32'h2000_0000, ACC_FETCH, 1'b0, 1'b1, 2'b00);
        chk_acc(1'b0, 32'h2000_0000, ACC_READ, 1'b0, 1'b0, 2'b10);
        chk_acc(1'b1, 32'h9000_0000, ACC_READ, 1'b0, 1'b0, 2'b10);
        @(posedge hclk);
        protection_set_select <= 2'h0;
        chk_acc(1'b0, 32'h1000_0000, ACC_READ, 1'b0, 1'b0, 2'b10);
    endtask
    // page path: each kind against every page enable pattern
    task automatic t_pages();
        for (int p = 0; p < 8; p++) begin
            for (int k = 0; k < 3; k++) begin
                @(posedge hclk);
                page_entry <= page_perm_t'(p);
                chk_acc(1'b1, 32'h2000_0040, acc_kind_t'(k), 1'b0, p[k], {~p[k], 1'b0});
            end
        end
    endtask
    // sticky status, mask and level interrupt
    task automatic t_irq();
        ahb(1'b0, OFF_STATUS, 32'h0);
        ahb(1'b1, OFF_MASK, 32'h3);
        chk_acc(1'b0, 32'hF000_0004, ACC_READ, 1'b1, 1'b0, 2'b01);
        `CHK("irq set", 1'b1, irq)
        ahb(1'b0, OFF_STATUS, 32'h0);
        `CHK("status", 32'h2, rd)
        `CHK("irq clear", 1'b0, irq)
        ahb(1'b1, OFF_MASK, 32'h1);
        chk_acc(1'b0, 32'hE000_0000, ACC_FETCH, 1'b1, 1'b0, 2'b01);
        `CHK("irq masked", 1'b0, irq)
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_priv();
        t_ranges();
        t_pages();
        t_irq();
        finish_test();
    end
endmodule
bind address_protection_checker prot_asserts u_chk (.hclk, .hresetn, .acc, .virtual_mode, .grant,
    .phys_addr_q, .grant_valid_q, .trap_handler, .virtual_address_protection_trap, .debug_illegal_q);
